// *** core/scsi_tgt_ctrl.sv ***
// Target-side parallel bus signal control with a Wishbone register slave
//
// Implementation choices: the register addresses and the Wishbone register port.
module scsi_tgt_ctrl (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // OR-tied lines
   input wire logic i_bsy,
   output logic o_bsy,
   output logic o_bsy_oe,
   input wire logic i_sel,
   output logic o_sel,
   output logic o_sel_oe,
   input wire logic i_rst,
   output logic o_rst,
   output logic o_rst_oe,
   // Phase and handshake lines
   input wire logic i_cd,
   output logic o_cd,
   output logic o_cd_oe,
   input wire logic i_io,
   output logic o_io,
   output logic o_io_oe,
   input wire logic i_msg,
   output logic o_msg,
   output logic o_msg_oe,
   output logic o_req,
   output logic o_req_oe,
   input wire logic i_ack,
   input wire logic i_atn,
   // Data bus and parity lines
   input wire logic [15:0] i_db,
   output logic [15:0] o_db,
   output logic [15:0] o_db_oe,
   input wire logic i_pcrca,
   output logic o_pcrca,
   output logic o_pcrca_oe,
   input wire logic i_p1,
   output logic o_p1,
   output logic o_p1_oe
);
   // Odd parity bit for one byte
   function automatic logic odd_par(input logic [7:0] b);
      odd_par = ~^b;
   endfunction : odd_par

   // Arbitration rank, higher wins
   function automatic logic [3:0] rank(input logic [3:0] id);
      rank = id[3] ? {1'b0, id[2:0]} : {1'b1, id[2:0]};
   endfunction : rank

   // Any bit on the bus of higher rank than own ID
   function automatic logic beaten(input logic [15:0] db,
                                   input logic [3:0] id);
      logic hit;
      hit = 1'b0;
      for (int b = 0; b < 16; b++) begin
         if (db[b] && rank(4'(b)) > rank(id)) begin
            hit = 1'b1;
         end
      end
      beaten = hit;
   endfunction : beaten

   // Byte-lane write merge
   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int k = 0; k < 4; k++) begin
         if (s[k]) begin
            r[8*k +: 8] = n[8*k +: 8];
         end
      end
      merge = r;
   endfunction : merge

   // Reset release
   logic [1:0] rst_sync;
   logic rst_b;
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_b = rst_sync[1];

   // Pin synchronisers
   localparam int NS = 24;
   logic [NS-1:0] pin_raw;
   logic [NS-1:0] pin_m;
   logic [NS-1:0] pin_s;
   assign pin_raw = {i_bsy, i_sel, i_rst, i_cd, i_io, i_msg, i_ack,
                     i_atn, i_db};
   always_ff @(posedge i_sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_m <= '0;
         pin_s <= '0;
      end else begin
         pin_m <= pin_raw;
         pin_s <= pin_m;
      end
   end
   logic bsy_s, sel_s, rst_s, cd_s, io_s, msg_s, ack_s, atn_s;
   logic [15:0] db_s;
   assign {bsy_s, sel_s, rst_s, cd_s, io_s, msg_s, ack_s, atn_s,
           db_s} = pin_s;
   logic [1:0] par_m;
   logic [1:0] par_s;
   always_ff @(posedge i_sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         par_m <= 2'h0;
         par_s <= 2'h0;
      end else begin
         par_m <= {i_p1, i_pcrca};
         par_s <= par_m;
      end
   end
   logic ack_d;
   logic ack_rise;
   always_ff @(posedge i_sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_d <= 1'b0;
      end else begin
         ack_d <= ack_s;
      end
   end
   assign ack_rise = ack_s && !ack_d;

   // Registers and state
   logic [15:0] ctrl;
   logic [7:0] ids;
   logic [16:0] txd;
   logic [16:0] rxd;
   logic [15:0] req_cnt;
   logic [15:0] ack_cnt;
   logic lost, perr, qas_seen, rst_seen, rx_new;
   scsi_tgt_pkg::link_t lst;
   scsi_tgt_pkg::xfer_t xst;
   logic [7:0] tmr;

   // Bus access decode
   logic acc, wr, rd;
   assign acc = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign wr = acc && i_wb_we;
   assign rd = acc && !i_wb_we;
   logic wr_ctrl, wr_id, wr_xfer, wr_stat, wr_cnt;
   assign wr_ctrl = wr && i_wb_adr == scsi_tgt_pkg::ADR_CTRL;
   assign wr_id = wr && i_wb_adr == scsi_tgt_pkg::ADR_ID;
   assign wr_xfer = wr && i_wb_adr == scsi_tgt_pkg::ADR_XFER;
   assign wr_stat = wr && i_wb_adr == scsi_tgt_pkg::ADR_STAT;
   assign wr_cnt = wr && i_wb_adr == scsi_tgt_pkg::ADR_CNT;
   logic [31:0] wdat_ctrl;
   assign wdat_ctrl = merge({16'h0000, ctrl}, i_wb_dat, i_wb_sel);

   // Phase decode
   logic conn, sync_mode, dt_ph, st_ph, ctl_ph, msg_in, drv_db;
   assign conn = lst == scsi_tgt_pkg::L_CONN;
   assign sync_mode = ctrl[scsi_tgt_pkg::C_SYNC];
   assign ctl_ph = ctrl[scsi_tgt_pkg::C_CD];
   assign dt_ph = conn && !ctl_ph && ctrl[scsi_tgt_pkg::C_MSG];
   assign st_ph = !ctl_ph && !ctrl[scsi_tgt_pkg::C_MSG];
   assign drv_db = conn && ctrl[scsi_tgt_pkg::C_IO];
   assign msg_in = cd_s && io_s && msg_s;
   logic grp_mode;
   assign grp_mode = ctrl[scsi_tgt_pkg::C_DG] || ctrl[scsi_tgt_pkg::C_IU];

   // Control register; command bits self-clear
   always_ff @(posedge i_sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= scsi_tgt_pkg::CTRL_RST_VAL;
      end else if (wr_ctrl) begin
         ctrl <= wdat_ctrl[15:0];
      end else begin
         ctrl[scsi_tgt_pkg::C_RESEL] <= 1'b0;
         ctrl[scsi_tgt_pkg::C_DISC] <= 1'b0;
      end
   end

   // Own and initiator IDs
   always_ff @(posedge i_sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ids <= 8'h00;
      end else if (wr_id && i_wb_sel[0]) begin
         ids <= i_wb_dat[7:0];
      end
   end
   logic [3:0] own_id, ini_id;
   logic [15:0] own_bit, ini_bit;
   assign own_id = ids[3:0];
   assign ini_id = ids[7:4];
   assign own_bit = 16'h0001 << own_id;
   assign ini_bit = 16'h0001 << ini_id;

   // Link state: arbitration, reselection, connection
   always_ff @(posedge i_sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lst <= scsi_tgt_pkg::L_IDLE;
         tmr <= 8'h00;
         lost <= 1'b0;
      end else begin
         if (wr_stat && i_wb_dat[scsi_tgt_pkg::S_LOST]) begin
            lost <= 1'b0;
         end
         if (rst_s) begin
            lst <= scsi_tgt_pkg::L_IDLE;
         end else begin
            case (lst)
               scsi_tgt_pkg::L_IDLE: begin
                  tmr <= 8'h00;
                  if (ctrl[scsi_tgt_pkg::C_RESEL]) begin
                     if (!bsy_s && !sel_s) begin
                        lst <= scsi_tgt_pkg::L_ARB;
                     end else begin
                        lost <= 1'b1;
                     end
                  end
               end
               scsi_tgt_pkg::L_ARB: begin
                  tmr <= tmr + 8'h01;
                  if (sel_s || beaten(db_s, own_id)) begin
                     lst <= scsi_tgt_pkg::L_IDLE;
                     lost <= 1'b1;
                  end else if (tmr == 8'(scsi_tgt_pkg::ARB_CYC)) begin
                     lst <= scsi_tgt_pkg::L_RESEL;
                     tmr <= 8'h00;
                  end
               end
               scsi_tgt_pkg::L_RESEL: begin
                  tmr <= tmr + 8'h01;
                  if (tmr == 8'(scsi_tgt_pkg::ARB_CYC)) begin
                     lst <= scsi_tgt_pkg::L_RWAIT;
                  end
               end
               scsi_tgt_pkg::L_RWAIT: begin
                  if (bsy_s) begin
                     lst <= scsi_tgt_pkg::L_CONN;
                  end
               end
               scsi_tgt_pkg::L_CONN: begin
                  if (ctrl[scsi_tgt_pkg::C_DISC]) begin
                     lst <= scsi_tgt_pkg::L_IDLE;
                  end
               end
               default: lst <= scsi_tgt_pkg::L_IDLE;
            endcase
         end
      end
   end

   // Transfer data latch
   always_ff @(posedge i_sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         txd <= 17'h0_0000;
      end else if (wr_xfer && xst == scsi_tgt_pkg::X_IDLE) begin
         txd <= i_wb_dat[16:0];
      end
   end

   // REQ sequencer
   logic req;
   always_ff @(posedge i_sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         xst <= scsi_tgt_pkg::X_IDLE;
         req <= 1'b0;
      end else if (!conn) begin
         xst <= scsi_tgt_pkg::X_IDLE;
         req <= 1'b0;
      end else begin
         case (xst)
            scsi_tgt_pkg::X_IDLE: begin
               if (wr_xfer) begin
                  req <= 1'b1;
                  xst <= scsi_tgt_pkg::X_REQ;
               end
            end
            scsi_tgt_pkg::X_REQ: begin
               if (sync_mode) begin
                  req <= 1'b0;
                  xst <= scsi_tgt_pkg::X_GAP;
               end else if (ack_s) begin
                  req <= 1'b0;
                  xst <= scsi_tgt_pkg::X_ACKLOW;
               end
            end
            scsi_tgt_pkg::X_ACKLOW: begin
               if (!ack_s) begin
                  xst <= scsi_tgt_pkg::X_IDLE;
               end
            end
            scsi_tgt_pkg::X_GAP: xst <= scsi_tgt_pkg::X_IDLE;
            default: xst <= scsi_tgt_pkg::X_IDLE;
         endcase
      end
   end

   // REQ and ACK pulse counters
   always_ff @(posedge i_sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_cnt <= 16'h0000;
         ack_cnt <= 16'h0000;
      end else if (wr_cnt) begin
         req_cnt <= 16'h0000;
         ack_cnt <= 16'h0000;
      end else begin
         if (xst == scsi_tgt_pkg::X_IDLE && wr_xfer && conn) begin
            req_cnt <= req_cnt + 16'h0001;
         end
         if (ack_rise && conn) begin
            ack_cnt <= ack_cnt + 16'h0001;
         end
      end
   end

   // Receive capture and parity check
   logic cap, chk_lo, chk_hi, bad;
   assign cap = ack_rise && conn && !ctrl[scsi_tgt_pkg::C_IO];
   assign chk_lo = !(dt_ph && grp_mode);
   assign chk_hi = ctrl[scsi_tgt_pkg::C_WIDE] && !ctl_ph && !dt_ph;
   assign bad = (chk_lo && par_s[0] != odd_par(db_s[7:0])) ||
                (chk_hi && par_s[1] != odd_par(db_s[15:8]));
   always_ff @(posedge i_sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rxd <= 17'h0_0000;
         perr <= 1'b0;
         rx_new <= 1'b0;
      end else begin
         if (cap) begin
            rxd <= {par_s[0], db_s};
         end
         if (cap && bad) begin
            perr <= 1'b1;
         end else if (wr_stat && i_wb_dat[scsi_tgt_pkg::S_PERR]) begin
            perr <= 1'b0;
         end
         // Pad and pCRC fields are not handed on
         if (cap && !(dt_ph && ctrl[scsi_tgt_pkg::C_DG] &&
                      ctrl[scsi_tgt_pkg::C_PAD])) begin
            rx_new <= 1'b1;
         end else if (rd && i_wb_adr == scsi_tgt_pkg::ADR_RX) begin
            rx_new <= 1'b0;
         end
      end
   end

   // QAS request watch and reset seen
   always_ff @(posedge i_sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         qas_seen <= 1'b0;
         rst_seen <= 1'b0;
      end else begin
         if (ctrl[scsi_tgt_pkg::C_QAS] && msg_in && ack_rise &&
             db_s[7:0] == scsi_tgt_pkg::QAS_REQ_MSG) begin
            qas_seen <= 1'b1;
         end else if (wr_stat && i_wb_dat[scsi_tgt_pkg::S_QAS]) begin
            qas_seen <= 1'b0;
         end
         if (rst_s) begin
            rst_seen <= 1'b1;
         end else if (wr_stat && i_wb_dat[scsi_tgt_pkg::S_RSTSEEN]) begin
            rst_seen <= 1'b0;
         end
      end
   end

   // OR-tied lines: asserted or released, never driven false
   logic arb, rsel;
   assign arb = lst == scsi_tgt_pkg::L_ARB;
   assign rsel = lst == scsi_tgt_pkg::L_RESEL ||
                 lst == scsi_tgt_pkg::L_RWAIT;
   assign o_bsy = 1'b1;
   assign o_bsy_oe = arb || lst == scsi_tgt_pkg::L_RESEL || conn;
   assign o_sel = 1'b1;
   assign o_sel_oe = rsel;
   assign o_rst = 1'b1;
   assign o_rst_oe = ctrl[scsi_tgt_pkg::C_RST];

   // Phase lines
   assign o_cd = conn && ctrl[scsi_tgt_pkg::C_CD];
   assign o_cd_oe = rsel || conn;
   assign o_io = rsel || (conn && ctrl[scsi_tgt_pkg::C_IO]);
   assign o_io_oe = rsel || conn;
   assign o_msg = conn && ctrl[scsi_tgt_pkg::C_MSG];
   assign o_msg_oe = rsel || conn;
   assign o_req = req;
   assign o_req_oe = conn;

   // Data bus drive
   logic [15:0] dval;
   assign dval = rsel ? (own_bit | ini_bit) : txd[15:0];
   assign o_db = arb ? own_bit : dval;
   assign o_db_oe = arb ? own_bit : ((rsel || drv_db) ? 16'hFFFF
                                                      : 16'h0000);

   // P_CRCA source selection
   logic pcrca_v;
   always_comb begin
      pcrca_v = odd_par(dval[7:0]);
      if (dt_ph && ctrl[scsi_tgt_pkg::C_DG]) begin
         pcrca_v = ctrl[scsi_tgt_pkg::C_PAD];
      end else if (dt_ph && ctrl[scsi_tgt_pkg::C_IU]) begin
         if (ctrl[scsi_tgt_pkg::C_IO]) begin
            pcrca_v = ctrl[scsi_tgt_pkg::C_RS] &&
                      ctrl[scsi_tgt_pkg::C_LAST];
         end else begin
            pcrca_v = ctrl[scsi_tgt_pkg::C_WFC] &&
                      ctrl[scsi_tgt_pkg::C_LAST];
         end
      end
   end
   assign o_pcrca = pcrca_v;
   assign o_pcrca_oe = rsel || drv_db ||
                       (conn && dt_ph && grp_mode);

   // P1 source selection
   logic p1_v, p1_en;
   always_comb begin
      p1_v = odd_par(dval[15:8]);
      p1_en = 1'b0;
      if (rsel) begin
         p1_en = ctrl[scsi_tgt_pkg::C_WIDE];
      end else if (drv_db && !ctl_ph) begin
         if (st_ph) begin
            p1_en = ctrl[scsi_tgt_pkg::C_WIDE];
         end else begin
            p1_en = 1'b1;
            if (ctrl[scsi_tgt_pkg::C_IU] && ctrl[scsi_tgt_pkg::C_PACE]) begin
               p1_v = txd[scsi_tgt_pkg::X_VALID];
            end else if (grp_mode) begin
               p1_v = 1'b0;
            end
         end
      end
   end
   assign o_p1 = p1_v;
   assign o_p1_oe = p1_en;

   // Status word
   logic [31:0] stat;
   always_comb begin
      stat = 32'h0000_0000;
      stat[scsi_tgt_pkg::S_BUSY] = xst != scsi_tgt_pkg::X_IDLE;
      stat[scsi_tgt_pkg::S_CONN] = conn;
      stat[scsi_tgt_pkg::S_LOST] = lost;
      stat[scsi_tgt_pkg::S_PERR] = perr;
      stat[scsi_tgt_pkg::S_QAS] = qas_seen;
      stat[scsi_tgt_pkg::S_RSTSEEN] = rst_seen;
      stat[scsi_tgt_pkg::S_ATN] = atn_s;
      stat[scsi_tgt_pkg::S_EQ] = req_cnt == ack_cnt;
      stat[scsi_tgt_pkg::S_RXNEW] = rx_new;
   end

   // Read mux and acknowledge
   logic [31:0] rdat;
   always_comb begin
      case (i_wb_adr)
         scsi_tgt_pkg::ADR_CTRL: rdat = {16'h0000, ctrl};
         scsi_tgt_pkg::ADR_ID: rdat = {24'h00_0000, ids};
         scsi_tgt_pkg::ADR_XFER: rdat = {15'h0000, txd};
         scsi_tgt_pkg::ADR_STAT: rdat = stat;
         scsi_tgt_pkg::ADR_RX: rdat = {15'h0000, rxd};
         scsi_tgt_pkg::ADR_CNT: rdat = {ack_cnt, req_cnt};
         default: rdat = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge i_sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= acc;
         if (rd) begin
            o_wb_dat <= rdat;
         end
      end
   end
endmodule : scsi_tgt_ctrl

// *** core/scsi_tgt_pkg.sv ***
// Constants, register map and state types for the bus target controller
package scsi_tgt_pkg;
   // Register byte offsets
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_ID = 8'h04;
   localparam logic [7:0] ADR_XFER = 8'h08;
   localparam logic [7:0] ADR_STAT = 8'h0C;
   localparam logic [7:0] ADR_RX = 8'h10;
   localparam logic [7:0] ADR_CNT = 8'h14;
   // Control register fields
   localparam int C_WIDE = 0;
   localparam int C_SYNC = 1;
   localparam int C_DG = 2;
   localparam int C_IU = 3;
   localparam int C_WFC = 4;
   localparam int C_RS = 5;
   localparam int C_PACE = 6;
   localparam int C_QAS = 7;
   localparam int C_CD = 8;
   localparam int C_IO = 9;
   localparam int C_MSG = 10;
   localparam int C_LAST = 11;
   localparam int C_PAD = 12;
   localparam int C_RST = 13;
   localparam int C_RESEL = 14;
   localparam int C_DISC = 15;
   localparam logic [15:0] CTRL_RST_VAL = 16'h0000;
   // Status register fields
   localparam int S_BUSY = 0;
   localparam int S_CONN = 1;
   localparam int S_LOST = 2;
   localparam int S_PERR = 3;
   localparam int S_QAS = 4;
   localparam int S_RSTSEEN = 5;
   localparam int S_ATN = 6;
   localparam int S_EQ = 7;
   localparam int S_RXNEW = 8;
   // Transfer register: paced data-valid flag
   localparam int X_VALID = 16;
   // QAS REQUEST message code
   localparam logic [7:0] QAS_REQ_MSG = 8'h55;
   // Arbitration and selection wait
   localparam int ARB_DELAY_NS = 2400;
   localparam int CLK_MHZ = 10;
   localparam int ARB_CYC = (ARB_DELAY_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_ARB = 3'b001,
      L_RESEL = 3'b010,
      L_RWAIT = 3'b011,
      L_CONN = 3'b100
   } link_t;
   typedef enum logic [1:0] {
      X_IDLE = 2'b00,
      X_REQ = 2'b01,
      X_ACKLOW = 2'b10,
      X_GAP = 2'b11
   } xfer_t;
endpackage : scsi_tgt_pkg

// *** dv/scsi_tgt_monitor.sv ***
// Port checker for the bus target controller
module scsi_tgt_monitor (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // OR-tied drives
   input wire logic o_bsy,
   input wire logic o_bsy_oe,
   input wire logic o_sel,
   input wire logic o_sel_oe,
   input wire logic o_rst,
   input wire logic o_rst_oe,
   // Phase and handshake drives
   input wire logic o_cd,
   input wire logic o_io,
   input wire logic o_io_oe,
   input wire logic o_msg,
   input wire logic o_req,
   input wire logic o_req_oe,
   // Data and parity drives
   input wire logic [15:0] o_db,
   input wire logic [15:0] o_db_oe,
   input wire logic o_pcrca,
   input wire logic o_pcrca_oe,
   input wire logic o_p1,
   input wire logic o_p1_oe
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_b);
   req_drive_a: assert property (o_req |-> o_req_oe)
      else $error("REQ high without drive enable");
   or_tied_a: assert property (!(o_bsy_oe && !o_bsy || o_sel_oe && !o_sel
      || o_rst_oe && !o_rst))
      else $error("OR-tied line driven false");
   low_parity_a: assert property ((o_req || o_sel_oe) && o_pcrca_oe
      && &o_db_oe[7:0] && !(o_msg && !o_cd) |-> ^{o_db[7:0], o_pcrca})
      else $error("Low byte parity even");
   high_parity_a: assert property ((o_req || o_sel_oe) && o_p1_oe
      && &o_db_oe[15:8] && !(o_msg && !o_cd) |-> ^{o_db[15:8], o_p1})
      else $error("High byte parity even");
   no_p1_a: assert property (o_req && o_cd |-> !o_p1_oe)
      else $error("P1 driven in control phase");
   data_dir_a: assert property (o_req |->
      o_db_oe[7:0] == {8{o_io_oe & o_io}})
      else $error("Data drive against I/O direction");
   arb_bit_a: assert property (o_bsy_oe && !o_sel_oe && !o_req_oe |->
      $onehot(o_db_oe) && (o_db_oe & ~o_db) == 16'h0000)
      else $error("Arbitration drives more than own bit");
   resel_io_a: assert property (o_sel_oe && o_bsy_oe |-> o_io_oe && o_io)
      else $error("Reselection without I/O asserted");
   sel_hold_a: assert property ($rose(o_sel_oe) |-> o_sel_oe[*8])
      else $error("SEL released too early");
endmodule : scsi_tgt_monitor

// *** dv/init_model.sv ***
// Initiator model: answers REQ with ACK, drives data when I/O is negated
module init_model (
   // Clock
   input wire logic i_clk,
   // Bus lines seen
   input wire logic i_req,
   input wire logic i_io,
   input wire logic i_sel,
   input wire logic [15:0] i_db,
   // Stimulus from the bench
   input wire logic [15:0] i_data,
   input wire logic i_bad,
   input wire logic i_sync,
   // Lines driven
   output logic o_ack,
   output logic o_bsy,
   output logic o_drv,
   output logic [15:0] o_db,
   output logic o_pcrca,
   output logic o_p1,
   // Observations
   output int o_count,
   output logic [15:0] o_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_ack = 1'b0;
      o_bsy = 1'b0;
      o_count = 0;
      o_seen = 16'h0000;
   end
   always @(posedge i_clk) begin
      o_bsy <= i_sel & i_io & i_db[7];
      // Sync mode: every one-cycle REQ pulse gets its ACK
      if (i_req && !o_ack && (i_sync || $urandom_range(1, 0) == 1)) begin
         o_ack <= 1'b1;
         o_count <= o_count + 1;
         o_seen <= i_db;
      end else if (!i_req) begin
         o_ack <= 1'b0;
      end
   end
   // Released data lines fall to the terminator level
   assign o_drv = !i_io && (i_req || o_ack);
   assign o_db = i_data;
   assign o_pcrca = ~^i_data[7:0] ^ i_bad;
   assign o_p1 = ~^i_data[15:8];
endmodule : init_model

// *** dv/parallel_bus_target_signal_control_test.sv ***
// Self-checking bench for the bus target controller
module parallel_bus_target_signal_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_sys_clk = 0, i_rst_b = 0, i_wb_cyc = 0, i_wb_stb = 0;
   logic i_wb_we = 0, t_rst = 0, i_atn = 0, bad = 0, sync_m = 0;
   logic [7:0] i_wb_adr = 8'h00;
   logic [3:0] i_wb_sel = 4'hf, id;
   logic [31:0] i_wb_dat = 32'h0000_0000, o_wb_dat, r;
   logic [15:0] pdat = 16'h0000, p_db, o_db, o_db_oe, i_db, seen, d;
   logic o_wb_ack, o_bsy, o_bsy_oe, o_sel, o_sel_oe, o_rst, o_rst_oe;
   logic o_cd, o_cd_oe, o_io, o_io_oe, o_msg, o_msg_oe, o_req, o_req_oe;
   logic o_pcrca, o_pcrca_oe, o_p1, o_p1_oe, i_ack, p_bsy, p_drv, p_pc;
   logic p_p1, i_bsy, i_sel, i_rst, i_cd, i_io, i_msg, i_pcrca, i_p1;
   int fail_count = 0, check_count = 0, n = 0, cnt, c;
   always #50 i_sys_clk = ~i_sys_clk;
   assign i_bsy = o_bsy_oe & o_bsy | p_bsy;
   assign i_sel = o_sel_oe & o_sel;
   assign i_rst = o_rst_oe & o_rst | t_rst;
   assign i_cd = o_cd_oe & o_cd;
   assign i_io = o_io_oe & o_io;
   assign i_msg = o_msg_oe & o_msg;
   assign i_db = o_db & o_db_oe | (p_drv ? p_db : 16'h0000);
   assign i_pcrca = o_pcrca_oe & o_pcrca | p_drv & p_pc;
   assign i_p1 = o_p1_oe & o_p1 | p_drv & p_p1;
   scsi_tgt_ctrl DUT (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
      .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
      .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_bsy(i_bsy),
      .o_bsy(o_bsy), .o_bsy_oe(o_bsy_oe), .i_sel(i_sel), .o_sel(o_sel),
      .o_sel_oe(o_sel_oe), .i_rst(i_rst), .o_rst(o_rst),
      .o_rst_oe(o_rst_oe), .i_cd(i_cd), .o_cd(o_cd), .o_cd_oe(o_cd_oe),
      .i_io(i_io), .o_io(o_io), .o_io_oe(o_io_oe), .i_msg(i_msg),
      .o_msg(o_msg), .o_msg_oe(o_msg_oe), .o_req(o_req),
      .o_req_oe(o_req_oe), .i_ack(i_ack), .i_atn(i_atn), .i_db(i_db),
      .o_db(o_db), .o_db_oe(o_db_oe), .i_pcrca(i_pcrca),
      .o_pcrca(o_pcrca), .o_pcrca_oe(o_pcrca_oe), .i_p1(i_p1),
      .o_p1(o_p1), .o_p1_oe(o_p1_oe));
   init_model PM (.i_clk(i_sys_clk), .i_req(o_req), .i_io(i_io),
      .i_sel(i_sel), .i_db(i_db), .i_data(pdat), .i_bad(bad),
      .i_sync(sync_m),
      .o_ack(i_ack), .o_bsy(p_bsy), .o_drv(p_drv), .o_db(p_db),
      .o_pcrca(p_pc), .o_p1(p_p1), .o_count(cnt), .o_seen(seen));
   task automatic tally_and_finish;
      if (fail_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic hang;
      fail_count++;
      tally_and_finish();
   endtask : hang
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] v);
      int k = 0;
      @(posedge i_sys_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= w;
      i_wb_adr <= a;
      i_wb_dat <= v;
      do begin
         @(posedge i_sys_clk);
         k++;
      end while (o_wb_ack !== 1'b1 && k < 20);
      if (k >= 20) hang();
      r = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
   endtask : wb
   task automatic poll(input int b, input logic v);
      int k = 0;
      do begin
         wb(0, scsi_tgt_pkg::ADR_STAT, 0);
         k++;
      end while (r[b] !== v && k < 100);
      if (k >= 100) hang();
   endtask : poll
   task automatic xfer(input logic [15:0] v);
      int c0 = cnt;
      wb(1, scsi_tgt_pkg::ADR_XFER, {16'h0000, v});
      n++;
      poll(scsi_tgt_pkg::S_BUSY, 0);
      chk(32'(cnt), 32'(c0 + 1));
   endtask : xfer
   initial begin
      #5_000_000;
      hang();
   end
   initial begin
      void'($urandom(90128));
      repeat (12) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      wb(1, 8'h1C, 32'hFFFF_FFFF);
      id = 4'($urandom % 7);
      wb(1, scsi_tgt_pkg::ADR_ID, {28'h000_0007, id});
      wb(1, scsi_tgt_pkg::ADR_CTRL, 32'h0000_4201);
      poll(scsi_tgt_pkg::S_CONN, 1);
      for (int i = 0; i < 4; i++) begin
         d = 16'($urandom);
         xfer(d);
         chk(32'(seen), 32'(d));
      end
      c = cnt;
      d = 16'($urandom);
      wb(1, scsi_tgt_pkg::ADR_XFER, {16'h0000, d});
      wb(1, scsi_tgt_pkg::ADR_XFER, {16'h0000, ~d});
      n++;
      poll(scsi_tgt_pkg::S_BUSY, 0);
      chk(32'(cnt), 32'(c + 1));
      chk(32'(seen), 32'(d));
      sync_m <= 1'b1;
      wb(1, scsi_tgt_pkg::ADR_CTRL, 32'h0000_0203);
      for (int i = 0; i < 3; i++) begin
         d = 16'($urandom);
         xfer(d);
         chk(32'(seen), 32'(d));
      end
      wb(0, scsi_tgt_pkg::ADR_CNT, 0);
      chk(r, {n[15:0], n[15:0]});
      poll(scsi_tgt_pkg::S_EQ, 1);
      wb(1, scsi_tgt_pkg::ADR_CTRL, 32'h0000_0001);
      for (int b = 0; b < 2; b++) begin
         d = 16'($urandom);
         pdat <= d;
         bad <= b[0];
         xfer(16'h0000);
         wb(0, scsi_tgt_pkg::ADR_RX, 0);
         chk(r, {15'h0000, ~^d[7:0] ^ b[0], d});
         wb(0, scsi_tgt_pkg::ADR_STAT, 0);
         chk(32'(r[scsi_tgt_pkg::S_PERR]), 32'(b));
         wb(1, scsi_tgt_pkg::ADR_STAT, 32'h0000_0008);
      end
      wb(1, scsi_tgt_pkg::ADR_CTRL, 32'h0000_0780);
      xfer({8'h00, scsi_tgt_pkg::QAS_REQ_MSG});
      chk(32'(seen[7:0]), 32'(scsi_tgt_pkg::QAS_REQ_MSG));
      wb(0, scsi_tgt_pkg::ADR_STAT, 0);
      chk(32'(r[scsi_tgt_pkg::S_QAS]), 32'h0000_0001);
      i_atn <= 1'b1;
      t_rst <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      t_rst <= 1'b0;
      wb(0, scsi_tgt_pkg::ADR_STAT, 0);
      chk(32'(r[scsi_tgt_pkg::S_ATN]), 32'h0000_0001);
      chk(32'(r[scsi_tgt_pkg::S_RSTSEEN]), 32'h0000_0001);
      chk(32'(r[scsi_tgt_pkg::S_CONN]), 32'h0000_0000);
      tally_and_finish();
   end
endmodule : parallel_bus_target_signal_control_test
bind scsi_tgt_ctrl scsi_tgt_monitor MON (.i_sys_clk(i_sys_clk),
   .i_rst_b(i_rst_b), .o_bsy(o_bsy), .o_bsy_oe(o_bsy_oe), .o_sel(o_sel),
   .o_sel_oe(o_sel_oe), .o_rst(o_rst), .o_rst_oe(o_rst_oe), .o_cd(o_cd),
   .o_io(o_io), .o_io_oe(o_io_oe), .o_msg(o_msg), .o_req(o_req),
   .o_req_oe(o_req_oe), .o_db(o_db), .o_db_oe(o_db_oe), .o_pcrca(o_pcrca),
   .o_pcrca_oe(o_pcrca_oe), .o_p1(o_p1), .o_p1_oe(o_p1_oe));
